// ===== sab_pkg.sv
`default_nettype none
package sab_pkg;
  // register byte offsets on the bus
  localparam logic [7:0]  SEG_DESC0_OFS = 8'h00;
  localparam logic [7:0]  DEF_DESC_OFS  = 8'h20;
  localparam logic [7:0]  BANK_CTL0_OFS = 8'h40;
  localparam logic [7:0]  STATUS_OFS    = 8'h60;
  localparam logic [7:0]  REG_STRIDE    = 8'h04;
  // reset values and writable bits
  localparam logic [15:0] SEG_DESC_RST  = 16'h0000;
  localparam logic [15:0] DEF_DESC_RST  = 16'h7801;
  localparam logic [15:0] BANK_CTL_RST  = 16'hf003;
  localparam logic [15:0] DESC_WMASK    = 16'h7dff;
  // segment descriptor fields
  localparam int SYS_PRIV_LO  = 13;
  localparam int USER_PRIV_LO = 11;
  localparam int CACHE_BIT    = 10;
  localparam int HALF_BIT     = 8;
  localparam int BANK_SEL_LO  = 0;
  // bank control fields
  localparam int BUS_SIZE_BIT = 15;
  localparam int WAIT_LO      = 12;
  localparam int CE_CTL_LO    = 0;
  // status fields
  localparam int STAT_BANK_LO = 0;
  localparam int STAT_ABORT   = 4;
  localparam int STAT_CACHE   = 5;
  localparam int STAT_BUSY    = 6;
  // counts
  localparam int NUM_SEG      = 8;
  localparam int NUM_SRAM     = 6;
  localparam logic [3:0] EXTRA_BANK = 4'h8;
  localparam logic [3:0] SYNC_CYC   = 4'h2;
  // request sources and effective transfer sizes
  typedef enum logic [1:0] {SAB_SRC_CORE, SAB_SRC_WBACK, SAB_SRC_LCD} sab_src_e;
  typedef enum logic [1:0] {SAB_SZ_BYTE, SAB_SZ_HALF, SAB_SZ_WORD} sab_size_e;
endpackage : sab_pkg
`default_nettype wire

// ===== sab_ce_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sab_ce_if;
  import sab_pkg::*;
  logic        a0;
  logic        bus16;
  sab_size_e   size;
  logic [11:0] ce_ctl;
  logic [5:0]  act;
  modport ctl (output a0, output bus16, output size, output ce_ctl, input act);
  modport pin (input a0, input bus16, input size, input ce_ctl, output act);
endinterface : sab_ce_if
`default_nettype wire

// ===== sab_ce_pin.sv
`timescale 1ns/1ps
`default_nettype none
module sab_ce_pin
  import sab_pkg::*;
#(
  parameter int IDX = 0
) (
  // shared transfer description
  sab_ce_if.pin ce
);
  logic hi;
  logic lo;
  assign hi = ce.ce_ctl[2*IDX+1];
  assign lo = ce.ce_ctl[2*IDX];
  // byte lane decode
  // a x16 part takes whole half-words, otherwise a0 picks the lane
  assign ce.act[IDX] = (ce.bus16 && ce.size != SAB_SZ_BYTE) ? (hi | lo)
                     : ((hi & lo) | (lo & ~ce.a0) | (hi & ce.a0));
endmodule : sab_ce_pin
`default_nettype wire

// ===== sab_ctl.sv
// Function
// - Pick descriptor of the matching segment; default descriptor when none matches.
// - System privilege at 14:13, user privilege at 12:11; none, read, write, both.
// - System field applies outside user mode, user field only in user mode.
// - Privilege violation raises data abort, or prefetch abort for fetches.
// - Aborted writes never reach memory.
// - Check all core accesses, but never cache write-backs.
// - Display refresh is system level and never violates.
// - Cacheable bit 10 routes core access to cache, else to external bus.
// - Display requests ignore cacheable bit and go external.
// - Without half-word mode a word takes two transfers on x16, four byte transfers on x8.
// - Half-word mode turns each word access into one half-word access: one transfer on x16, two on x8.
// - Half-word reads sign-extend to 32 bits; writes drive low 16 bits.
// - Bank select bits 7:0 are one-hot, bit i selects bank i.
// - All-zero bank select chooses extra bank 8.
// - Descriptors reset to 0x0000, default descriptor to 0x7801.
// - Banks 0 to 5 are SRAM banks with own control register.
// - Bus-size bit 15 sets transfer count per access size.
// - Wait field 14:12 inserts 0 to 7 wait cycles per transfer.
// - Chip-enable field 11:0 gives each of six pins high and low bits.
// - Pin asserts per lane from a0, bus size and access size.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sab_ctl
  import sab_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // internal access request
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic        req_write,
  input  wire logic        req_byte,
  input  wire logic        req_user,
  input  wire logic        req_fetch,
  input  wire sab_src_e    req_src,
  input  wire logic [7:0]  seg_match,
  output logic             req_done,
  output logic [31:0]      req_rdata,
  output logic             data_abort,
  output logic             prefetch_abort,
  output logic             to_cache,
  // external bus
  output logic [25:0]      ext_addr,
  output logic [15:0]      ext_wdata,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_rdata,
  output logic [5:0]       ext_ce_n,
  output logic             ext_we_n,
  output logic             ext_oe_n,
  output logic             ext_bw,
  output logic [3:0]       ext_bank
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_SETUP, ST_XFER} sab_st_e;

  typedef struct packed {
    sab_st_e          st;
    logic [3:0]       cnt;
    logic [1:0]       xfer;
    logic [1:0]       last;
    logic [31:0]      addr;
    logic [31:0]      wdata;
    logic             write;
    logic             byte_acc;
    logic             user;
    logic             fetch;
    sab_src_e         src;
    logic [7:0]       match;
    sab_size_e        size;
    logic             bus16;
    logic [2:0]       waitc;
    logic [11:0]      ce_ctl;
    logic [31:0]      buffer;
    logic [8:0][15:0] sd;
    logic [5:0][15:0] bc;
    logic             dph;
    logic             hwr;
    logic [7:0]       ha;
    logic [31:0]      hrd;
    logic             hrdy;
    logic [15:0]      rd_s1;
    logic [15:0]      rd_s2;
    logic [25:0]      ext_addr;
    logic [15:0]      ext_wd;
    logic             doe;
    logic [5:0]       ce_n;
    logic             we_n;
    logic             oe_n;
    logic             bw;
    logic [3:0]       bank;
    logic             done;
    logic [31:0]      rdata;
    logic             dab;
    logic             pab;
    logic             to_cache;
    logic             last_abort;
    logic             last_cache;
  } sab_state_s;

  sab_state_s s;
  sab_state_s n;
  logic [15:0] dsel;
  logic [1:0]  priv;
  logic        viol;
  logic        cache;
  logic [3:0]  bank;
  logic        bus_acc;
  logic [15:0] rd;

  // chip-enable decode, one small module per pin
  sab_ce_if ce_if ();
  assign ce_if.a0    = s.ext_addr[0];
  assign ce_if.bus16 = s.bus16;
  assign ce_if.size  = s.size;
  assign ce_if.ce_ctl = s.ce_ctl;
  for (genvar i = 0; i < NUM_SRAM; i++) begin : g_pin
    sab_ce_pin #(.IDX(i)) sab_ce_pin_i (.ce(ce_if));
  end

  // descriptor select, privilege check and bank decode for the held request
  always_comb begin
    // lowest matching segment wins, default otherwise
    dsel = s.sd[NUM_SEG];
    for (int i = NUM_SEG - 1; i >= 0; i--) begin
      if (s.match[i]) begin
        dsel = s.sd[i];
      end
    end
    // user field only in user mode; display is system level
    priv = (s.user && s.src != SAB_SRC_LCD) ? dsel[USER_PRIV_LO +: 2]
                                            : dsel[SYS_PRIV_LO +: 2];
    // bit 0 grants read, bit 1 grants write
    // only core accesses are checked, write-backs skip it
    viol = (s.src == SAB_SRC_CORE) && !(s.write ? priv[1] : priv[0]);
    // cacheable bit routes core traffic to the cache
    // display requests stay on the external bus
    cache = dsel[CACHE_BIT] && (s.src == SAB_SRC_CORE);
    // no bit set selects the extra bank
    bank = EXTRA_BANK;
    // one-hot select, lowest set bit taken if misprogrammed
    for (int i = 7; i >= 0; i--) begin
      if (dsel[BANK_SEL_LO + i]) begin
        bank = 4'(i);
      end
    end
  end

  // one cycle of state update
  always_comb begin
    n          = s;
    n.done     = 1'b0;
    n.dab      = 1'b0;
    n.pab      = 1'b0;
    n.to_cache = 1'b0;
    n.hrdy     = 1'b1;
    // pin data passes two flops before use
    n.rd_s1 = ext_rdata;
    n.rd_s2 = s.rd_s1;
    rd      = s.rd_s2;

    // register write in the data phase, descriptors masked to writable bits, bank control unmasked
    if (s.dph && s.hwr) begin
      if (s.ha[7:5] == SEG_DESC0_OFS[7:5]) begin
        n.sd[s.ha[4:2]] = hwdata[15:0] & DESC_WMASK;
      end else if (s.ha == DEF_DESC_OFS) begin
        n.sd[NUM_SEG] = hwdata[15:0] & DESC_WMASK;
      end else if (s.ha[7:5] == BANK_CTL0_OFS[7:5] && s.ha[4:2] < 3'(NUM_SRAM)) begin
        // one control register per sram bank
        n.bc[s.ha[4:2]] = hwdata[15:0];
      end
    end
    // address phase; reads see a write of the previous transfer
    bus_acc = hsel && htrans[1] && hready;
    n.dph   = bus_acc;
    n.hwr   = hwrite;
    n.ha    = {haddr[7:2], 2'b00};
    if (bus_acc && !hwrite) begin
      n.hrd = 32'h0;
      if (haddr[7:5] == SEG_DESC0_OFS[7:5]) begin
        n.hrd[15:0] = n.sd[haddr[4:2]];
      end else if (haddr[7:2] == DEF_DESC_OFS[7:2]) begin
        n.hrd[15:0] = n.sd[NUM_SEG];
      end else if (haddr[7:5] == BANK_CTL0_OFS[7:5] && haddr[4:2] < 3'(NUM_SRAM)) begin
        n.hrd[15:0] = n.bc[haddr[4:2]];
      end else if (haddr[7:2] == STATUS_OFS[7:2]) begin
        n.hrd[STAT_BANK_LO +: 4] = s.bank;
        n.hrd[STAT_ABORT]        = s.last_abort;
        n.hrd[STAT_CACHE]        = s.last_cache;
        n.hrd[STAT_BUSY]         = (s.st != ST_IDLE);
      end
    end

    unique case (s.st)
      ST_IDLE: begin
        // done blocks a second take of a still-high valid
        if (req_valid && !s.done) begin
          n.addr     = req_addr;
          n.wdata    = req_wdata;
          n.write    = req_write;
          n.byte_acc = req_byte;
          n.user     = req_user;
          n.fetch    = req_fetch;
          n.src      = req_src;
          n.match    = seg_match;
          n.st       = ST_CHECK;
        end
      end
      ST_CHECK: begin
        n.bank = bank;
        // decision taken while all strobes are still idle
        if (viol) begin
          // abort kind follows fetch or data
          // an aborted write never enters setup
          n.dab        = !s.fetch;
          n.pab        = s.fetch;
          n.done       = 1'b1;
          n.last_abort = 1'b1;
          n.last_cache = 1'b0;
          n.st         = ST_IDLE;
        end else if (cache) begin
          n.to_cache   = 1'b1;
          n.done       = 1'b1;
          n.last_abort = 1'b0;
          n.last_cache = 1'b1;
          n.st         = ST_IDLE;
        end else begin
          n.last_abort = 1'b0;
          n.last_cache = 1'b0;
          // sram bank properties; dram and extra bank get no enables
          if (bank < 4'(NUM_SRAM)) begin
            n.bus16 = s.bc[bank[2:0]][BUS_SIZE_BIT];
            n.waitc = s.bc[bank[2:0]][WAIT_LO +: 3];
            // two enable bits per pin from the bank register
            n.ce_ctl = s.bc[bank[2:0]][CE_CTL_LO +: 12];
          end else begin
            n.bus16 = 1'b1;
            n.waitc = 3'h0;
            n.ce_ctl = 12'h000;
          end
          // half-word mode turns a word into a half-word
          if (s.byte_acc) begin
            n.size = SAB_SZ_BYTE;
          end else if (dsel[HALF_BIT]) begin
            n.size = SAB_SZ_HALF;
          end else begin
            n.size = SAB_SZ_WORD;
          end
          // transfer count from bus size and access size
          // a full word on x16 is two transfers
          if (s.byte_acc) begin
            n.last = 2'h0;
          end else if (dsel[HALF_BIT]) begin
            n.last = n.bus16 ? 2'h0 : 2'h1;
          end else begin
            n.last = n.bus16 ? 2'h1 : 2'h3;
          end
          n.xfer     = 2'h0;
          n.buffer   = 32'h0;
          n.ext_addr = s.addr[25:0];
          n.st       = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // write data per transfer; half-word mode sends low 16 only
        if (s.size == SAB_SZ_BYTE) begin
          n.ext_wd = {s.wdata[7:0], s.wdata[7:0]};
        end else if (s.bus16) begin
          n.ext_wd = s.wdata[16*s.xfer[0] +: 16];
        end else begin
          n.ext_wd = {8'h00, s.wdata[8*s.xfer +: 8]};
        end
        // enables only for the sram bank being accessed
        n.ce_n = ~(ce_if.act & {6{s.bank < 4'(NUM_SRAM)}});
        n.we_n = ~s.write;
        n.oe_n = s.write;
        n.doe  = s.write;
        n.bw   = (s.size == SAB_SZ_BYTE);
        n.cnt  = 4'h0;
        n.st   = ST_XFER;
      end
      ST_XFER: begin
        n.cnt = s.cnt + 4'h1;
        // strobe held for wait count plus sampling delay
        if (s.cnt == {1'b0, s.waitc} + SYNC_CYC) begin
          if (s.size == SAB_SZ_BYTE) begin
            n.buffer[7:0] = (s.bus16 && s.ext_addr[0]) ? rd[15:8] : rd[7:0];
          end else if (s.bus16) begin
            n.buffer[16*s.xfer[0] +: 16] = rd;
          end else begin
            n.buffer[8*s.xfer +: 8] = rd[7:0];
          end
          n.ce_n = 6'h3f;
          n.we_n = 1'b1;
          n.oe_n = 1'b1;
          n.doe  = 1'b0;
          n.bw   = 1'b0;
          if (s.xfer == s.last) begin
            n.rdata = (s.size == SAB_SZ_HALF) ? {{16{n.buffer[15]}}, n.buffer[15:0]}
                                              : n.buffer;
            n.done  = 1'b1;
            n.st    = ST_IDLE;
          end else begin
            n.xfer     = s.xfer + 2'h1;
            n.ext_addr = s.ext_addr + (s.bus16 ? 26'h2 : 26'h1);
            n.st       = ST_SETUP;
          end
        end
      end
    endcase
  end

  // single state register; sync reset to constants
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.src      <= SAB_SRC_CORE;
      s.size     <= SAB_SZ_WORD;
      s.hrdy     <= 1'b1;
      s.ce_n     <= 6'h3f;
      s.we_n     <= 1'b1;
      s.oe_n     <= 1'b1;
      s.bank     <= 4'h0;
      s.sd       <= {DEF_DESC_RST, {NUM_SEG{SEG_DESC_RST}}};
      s.bc       <= {NUM_SRAM{BANK_CTL_RST}};
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register, except hresp which is tied low
  assign hreadyout      = s.hrdy;
  assign hresp          = 1'b0;
  assign hrdata         = s.hrd;
  assign req_done       = s.done;
  assign req_rdata      = s.rdata;
  assign data_abort     = s.dab;
  assign prefetch_abort = s.pab;
  assign to_cache       = s.to_cache;
  assign ext_addr       = s.ext_addr;
  assign ext_wdata      = s.ext_wd;
  assign ext_data_oe    = s.doe;
  assign ext_ce_n       = s.ce_n;
  assign ext_we_n       = s.we_n;
  assign ext_oe_n       = s.oe_n;
  assign ext_bw         = s.bw;
  assign ext_bank       = s.bank;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_check_viol;
    s.st == ST_CHECK && viol;
  endsequence
  sequence s_abort_quiet;
    (s.dab ^ s.pab) && s.done && s.ce_n == 6'h3f && s.we_n ##1 s.st == ST_IDLE && s.we_n;
  endsequence

  property p_reset_desc;
    $past(sys_rst) |-> s.sd[NUM_SEG] == DEF_DESC_RST && s.sd[0] == SEG_DESC_RST;
  endproperty
  a_reset_desc: assert property (p_reset_desc) else $error("descriptor reset wrong");

  property p_abort;
    s_check_viol |=> s_abort_quiet;
  endproperty
  a_abort: assert property (p_abort) else $error("violation not aborted cleanly");

  property p_abort_kind;
    s_check_viol |=> (s.pab == s.fetch) && (s.dab == !s.fetch);
  endproperty
  a_abort_kind: assert property (p_abort_kind) else $error("wrong abort kind");

  property p_no_check;
    s.st == ST_CHECK && s.src != SAB_SRC_CORE |=> !s.dab && !s.pab;
  endproperty
  a_no_check: assert property (p_no_check) else $error("unchecked source aborted");

  property p_lcd_ext;
    s.st == ST_CHECK && s.src == SAB_SRC_LCD |=> !s.to_cache && s.st == ST_SETUP;
  endproperty
  a_lcd_ext: assert property (p_lcd_ext) else $error("display request not external");

  property p_cache;
    s.st == ST_CHECK && !viol && cache |=> s.to_cache && s.done ##1 s.ce_n == 6'h3f;
  endproperty
  a_cache: assert property (p_cache) else $error("cacheable access not routed");

  property p_bank8;
    s.st == ST_CHECK && dsel[7:0] == 8'h00 |=> s.bank == EXTRA_BANK;
  endproperty
  a_bank8: assert property (p_bank8) else $error("empty select not bank 8");

  property p_wait;
    s.st == ST_XFER && n.st != ST_XFER |-> s.cnt == {1'b0, s.waitc} + SYNC_CYC;
  endproperty
  a_wait: assert property (p_wait) else $error("strobe length wrong");

  property p_strobe_late;
    // any strobe belongs to a transfer whose last check passed and went external
    (!s.we_n || !s.oe_n || s.ce_n != 6'h3f) |-> s.st == ST_XFER && !s.last_abort
                                                && !s.last_cache;
  endproperty
  a_strobe_late: assert property (p_strobe_late) else $error("strobe before check");

  property p_sext;
    s.st == ST_XFER && n.done && s.size == SAB_SZ_HALF |=> s.rdata[31:16] == {16{s.rdata[15]}};
  endproperty
  a_sext: assert property (p_sext) else $error("half-word read not sign-extended");
endmodule : sab_ctl
`default_nettype wire

// ===== sab_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sab_sram_model #(
  parameter int HOLD_CYC = 3
) (
  // pins from the bus controller
  input  wire logic        clk,
  input  wire logic [25:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [5:0]  ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        bw,
  // data pins back
  output logic [15:0]      rdata
);
  logic [15:0] mem [0:1023];
  logic [15:0] last;
  int          held = HOLD_CYC;
  wire         sel = ~&ce_n;
  // byte writes hit one lane chosen by a0, others both lanes
  always @(posedge clk) begin
    if (sel && !we_n && (!bw || !addr[0])) mem[addr[10:1]][7:0] <= wdata[7:0];
    if (sel && !we_n && (!bw || addr[0])) mem[addr[10:1]][15:8] <= wdata[15:8];
    if (sel && !oe_n) begin
      last <= mem[addr[10:1]];
      held <= 0;
    end else if (held < HOLD_CYC) begin
      held <= held + 1;
    end
  end
  // past the hold time the pins show the inverse, so stale data never passes
  assign rdata = (sel && !oe_n) ? mem[addr[10:1]] : (held < HOLD_CYC) ? last : ~last;
endmodule : sab_sram_model
`default_nettype wire

// ===== sab_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sab_ctl_tb;
  import sab_pkg::*;
  // bus and request drive
  logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, expv;
  logic        hready, hreadyout, hresp, req_done, data_abort, prefetch_abort, to_cache;
  logic        req_valid = 1'b0, req_write = 1'b0, req_byte = 1'b0;
  logic        req_user = 1'b0, req_fetch = 1'b0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, req_rdata;
  sab_src_e    req_src = SAB_SRC_CORE;
  logic [7:0]  seg_match = 8'h0;
  // external pins and monitor state
  logic [25:0] ext_addr;
  logic [15:0] ext_wdata, ext_rdata;
  logic [5:0]  ext_ce_n, ce_seen;
  logic [3:0]  ext_bank;
  logic [2:0]  fl;
  logic [1:0]  pr;
  logic        ext_data_oe, ext_we_n, ext_oe_n, ext_bw, bw_seen, doe_seen, ok;
  logic        prev_idle = 1'b1;
  int          failures = 0, samples_checked = 0, strobes = 0, nstr, cyc;

  assign hready = hreadyout;
  always #12.5 clk = ~clk;

  sab_ctl sab_ctl_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .req_valid, .req_addr, .req_wdata, .req_write, .req_byte,
    .req_user, .req_fetch, .req_src, .seg_match, .req_done, .req_rdata, .data_abort,
    .prefetch_abort, .to_cache, .ext_addr, .ext_wdata, .ext_data_oe, .ext_rdata, .ext_ce_n,
    .ext_we_n, .ext_oe_n, .ext_bw, .ext_bank);
  sab_sram_model sab_sram_model_i (.clk, .addr(ext_addr), .wdata(ext_wdata), .ce_n(ext_ce_n),
    .we_n(ext_we_n), .oe_n(ext_oe_n), .bw(ext_bw), .rdata(ext_rdata));

  // each strobe fall opens one external transfer
  always @(posedge clk) begin
    prev_idle <= ext_oe_n & ext_we_n;
    if (prev_idle && !(ext_oe_n & ext_we_n)) begin
      strobes <= strobes + 1;
      ce_seen <= ext_ce_n;
      bw_seen <= ext_bw;
      doe_seen <= ext_data_oe;
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // bounded wait on hready (0) or req_done (1)
  task automatic wait_for(input bit done_sig);
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while ((done_sig ? req_done : hready) !== 1'b1 && cyc < 300);
    if (cyc >= 300) begin
      failures++;
      $display("mismatch at %0t: no answer", $time);
      give_verdict();
    end
  endtask : wait_for

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_for(1'b0);
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(1'b0);
    q = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp, "register read");
  endtask : rchk

  // one request held until req_done is seen
  task automatic acc(input logic [31:0] a, d, input int w, b, u, f, input sab_src_e s,
                     input logic [7:0] m);
    int s0;
    // one idle edge after the last request, so valid is never set twice in a step
    @(posedge clk);
    s0 = strobes;
    req_addr <= a;
    req_wdata <= d;
    req_write <= 1'(w);
    req_byte <= 1'(b);
    req_user <= 1'(u);
    req_fetch <= 1'(f);
    req_src <= s;
    seg_match <= m;
    req_valid <= 1'b1;
    wait_for(1'b1);
    req_valid <= 1'b0;
    q = req_rdata;
    fl = {to_cache, prefetch_abort, data_abort};
    nstr = strobes - s0;
  endtask : acc

  // t transfers of (w + 4) cycles, or a check-only answer when t is 0
  task automatic expect_acc(input int t, w, input logic [2:0] fe);
    check(32'(cyc), (t == 0) ? 32'd3 : 32'(3 + t * (w + 4)), "request cycles");
    check(32'(nstr), 32'(t), "transfers");
    check({29'h0, fl}, {29'h0, fe}, "abort and cache flags");
  endtask : expect_acc

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(SEG_DESC0_OFS + 8'(4 * i), 32'h0);
    rchk(DEF_DESC_OFS, 32'h7801);
    for (int j = 0; j < 6; j++) rchk(BANK_CTL0_OFS + 8'(4 * j), 32'hf003);
    rchk(8'h80, 32'h0);
    bus(1'b1, SEG_DESC0_OFS, 32'hffff);
    rchk(SEG_DESC0_OFS, 32'h7dff);
    check({31'h0, hresp}, 32'h0, "response");
    $display("test registers done");
    // bank0 as x16 with no waits, then default segment word traffic
    bus(1'b1, BANK_CTL0_OFS, 32'h8003);
    acc(32'h100, 32'h8765_4321, 1, 0, 0, 0, SAB_SRC_CORE, 8'h0);
    expect_acc(2, 0, 3'h0);
    check({16'h0, sab_sram_model_i.mem[10'h80]}, 32'h4321, "low half first");
    acc(32'h100, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h0);
    expect_acc(2, 0, 3'h0);
    check(q, 32'h8765_4321, "word read");
    rchk(STATUS_OFS, 32'h0);
    acc(32'h200, 32'h5500, 1, 0, 0, 0, SAB_SRC_CORE, 8'h0);
    expv = 32'h5500;
    $display("test default segment done");
    // system and user fields differ, so the wrong field shows
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, SEG_DESC0_OFS + 8'h04, {17'h0, 2'(p), 2'(3 - p), 3'h0, 8'h01});
      for (int u = 0; u < 2; u++) begin
        for (int k = 0; k < 3; k++) begin
          pr = u ? 2'(3 - p) : 2'(p);
          ok = (k == 2) ? pr[1] : pr[0];
          acc(32'h200, 32'(16 * p + u + 1), k == 2, 0, u[0], k == 1, SAB_SRC_CORE, 8'h02);
          expect_acc(ok ? 2 : 0, 0, ok ? 3'h0 : (k == 1) ? 3'h2 : 3'h1);
          if (ok && k == 2) expv = 32'(16 * p + u + 1);
          check({16'h0, sab_sram_model_i.mem[10'h100]}, {16'h0, expv[15:0]}, "memory");
        end
      end
    end
    $display("test privileges done");
    // cacheable segment with system access only
    bus(1'b1, SEG_DESC0_OFS + 8'h04, 32'h6401);
    acc(32'h200, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h02);
    expect_acc(0, 0, 3'h4);
    acc(32'h200, 32'h0, 0, 0, 1, 0, SAB_SRC_CORE, 8'h02);
    expect_acc(0, 0, 3'h1);
    rchk(STATUS_OFS, 32'h10);
    acc(32'h204, 32'h77, 1, 0, 1, 0, SAB_SRC_WBACK, 8'h02);
    expect_acc(2, 0, 3'h0);
    acc(32'h200, 32'h0, 0, 0, 1, 0, SAB_SRC_LCD, 8'h02);
    expect_acc(2, 0, 3'h0);
    $display("test exemptions done");
    // half-word segment left non-cacheable
    acc(32'h300, 32'h0, 1, 0, 0, 0, SAB_SRC_CORE, 8'h0);
    bus(1'b1, SEG_DESC0_OFS + 8'h08, 32'h6101);
    acc(32'h300, 32'h1234_f00d, 1, 0, 0, 0, SAB_SRC_CORE, 8'h04);
    expect_acc(1, 0, 3'h0);
    check({sab_sram_model_i.mem[10'h181], sab_sram_model_i.mem[10'h180]}, 32'hf00d, "low");
    acc(32'h300, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h04);
    expect_acc(1, 0, 3'h0);
    check(q, 32'hffff_f00d, "sign extension");
    // odd byte on x16: lane by a0, byte pin up
    acc(32'h301, 32'h5a, 1, 1, 0, 0, SAB_SRC_CORE, 8'h0);
    expect_acc(1, 0, 3'h0);
    check({24'h0, doe_seen, bw_seen, ce_seen}, 32'hfe, "byte pins");
    acc(32'h300, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h0);
    check(q, 32'h5a0d, "byte merged");
    acc(32'h301, 32'h0, 0, 1, 0, 0, SAB_SRC_CORE, 8'h0);
    check(q, 32'h5a, "byte read");
    $display("test half and byte done");
    // x8 bank1 with two waits, bank2 at reset (seven waits), bank 8
    bus(1'b1, BANK_CTL0_OFS + 8'h04, 32'h200c);
    bus(1'b1, SEG_DESC0_OFS + 8'h0c, 32'h6002);
    acc(32'h400, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h08);
    expect_acc(4, 2, 3'h0);
    check({25'h0, doe_seen, ce_seen}, 32'h3d, "pin1 enable");
    rchk(STATUS_OFS, 32'h1);
    // half-word mode on the x8 bank takes two byte transfers
    bus(1'b1, SEG_DESC0_OFS + 8'h0c, 32'h6102);
    acc(32'h400, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h08);
    expect_acc(2, 2, 3'h0);
    bus(1'b1, SEG_DESC0_OFS + 8'h14, 32'h6004);
    acc(32'h400, 32'h0, 0, 1, 0, 0, SAB_SRC_CORE, 8'h20);
    expect_acc(1, 7, 3'h0);
    check({26'h0, ce_seen}, 32'h3e, "pin0 enable");
    bus(1'b1, SEG_DESC0_OFS + 8'h10, 32'h6000);
    acc(32'h400, 32'h0, 0, 0, 0, 0, SAB_SRC_CORE, 8'h10);
    expect_acc(2, 0, 3'h0);
    check({26'h0, ce_seen}, 32'h3f, "no enables");
    check({28'h0, ext_bank}, 32'h8, "bank eight");
    $display("test banks done");
    give_verdict();
  end
endmodule : sab_ctl_tb
`default_nettype wire
